/* File: rtl/pfi_pkg.sv */
// constants, word layouts and bcd helpers for the function instruction block
// assumes a 50 MHz clock and four-digit bcd words throughout
package pfi_pkg;
   // ==========================================================
   // clock and time bases (times in microseconds)
   localparam int CLK_MHZ    = 50;
   localparam int TB_1MS_US  = 1000;
   localparam int TB_10MS_US = 10000;
   localparam int TB_100MS_US = 100000;
   localparam int TB_1S_US   = 1000000;
   localparam int TB_1MS_CYC   = CLK_MHZ * TB_1MS_US;
   localparam int TB_10MS_CYC  = CLK_MHZ * TB_10MS_US;
   localparam int TB_100MS_CYC = CLK_MHZ * TB_100MS_US;
   localparam int TB_1S_CYC    = CLK_MHZ * TB_1S_US;
   localparam int NTB    = 4;
   localparam int TB_1MS = 0;
   localparam int TB_10MS = 1;
   localparam int TB_100MS = 2;
   localparam int TB_1S  = 3;
   localparam int DIV_W  = 26;
   // ==========================================================
   // timers, ranges and tables
   localparam int NTMR     = 5;
   localparam int TMR_FINE = 0;
   localparam int TMR_MS   = 1;
   localparam int TMR_POT  = 2;
   localparam int TMR_RNG1 = 3;
   localparam int TMR_RNG2 = 4;
   localparam logic [15:0] RNG_1S    = 16'h0000;
   localparam logic [15:0] RNG_100MS = 16'h0001;
   localparam logic [15:0] RNG_10MS  = 16'h0002;
   localparam logic [7:0]  POT_MIN   = 8'h01;
   localparam logic [7:0]  POT_MAX   = 8'hfa;
   localparam int NRANGE    = 10;
   localparam int TBL_WORDS = 1 + 2 * NRANGE;
   localparam logic [15:0] WORD_ZERO = 16'h0000;
   localparam logic [3:0]  DIGIT_MAX = 4'h9;
   localparam logic [3:0]  NRANGE_D  = 4'ha;

   // ==========================================================
   // bcd helpers
   function automatic logic [15:0] bcd_inc(input logic [15:0] v);
      logic [15:0] r;
      logic        c;
      r = v;
      c = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (c) begin
            if (r[4*i+:4] == DIGIT_MAX) r[4*i+:4] = 4'h0;
            else begin
               r[4*i+:4] = r[4*i+:4] + 4'h1;
               c = 1'b0;
            end
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] bcd_dec(input logic [15:0] v);
      logic [15:0] r;
      logic        b;
      r = v;
      b = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (b) begin
            if (r[4*i+:4] == 4'h0) r[4*i+:4] = DIGIT_MAX;
            else begin
               r[4*i+:4] = r[4*i+:4] - 4'h1;
               b = 1'b0;
            end
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] bin8_to_bcd(input logic [7:0] v);
      logic [7:0] h;
      logic [7:0] t;
      logic [7:0] u;
      h = v / 8'd100;
      t = (v / 8'd10) % 8'd10;
      u = v % 8'd10;
      return {4'h0, h[3:0], t[3:0], u[3:0]};
   endfunction
endpackage

/* File: rtl/pfi_tmr_if.sv */
// signals between the scan logic and one decrementing timer
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface pfi_tmr_if;
   logic        en;   // execution condition
   logic        tick; // one-cycle time base pulse
   logic [15:0] set;  // bcd reload value
   logic [15:0] pres; // bcd present value
   logic        done; // completion flag

   modport tmr (input en, input tick, input set, output pres, output done);
   modport ctl (output en, output tick, output set, input pres, input done);
endinterface

/* File: rtl/pfi_bcd_timer.sv */
// four-digit bcd decrementing timer with completion flag
// assumes tick is a one-cycle pulse at the timer's unit rate
`timescale 1ns/100ps
module pfi_bcd_timer (
   input wire logic clk,
   input wire logic rst_b,
   pfi_tmr_if.tmr   t
);
   // ==========================================================
   // count down, reload while the condition is off
   always_ff @(posedge clk) begin
      if (!rst_b) t.pres <= pfi_pkg::WORD_ZERO;
      else if (!t.en) t.pres <= t.set;
      else if (t.tick && t.pres != pfi_pkg::WORD_ZERO) begin
         t.pres <= pfi_pkg::bcd_dec(t.pres);
      end
   end

   // flag rises on the edge that empties the count
   always_ff @(posedge clk) begin
      if (!rst_b) t.done <= 1'b0;
      else t.done <= t.en && (t.pres == pfi_pkg::WORD_ZERO ||
                     (t.tick && t.pres == 16'h0001));
   end

   // ==========================================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence last_tick_s;
      t.en && t.tick && t.pres == 16'h0001;
   endsequence

   chk_tmr_reload: assert property (!t.en |=> t.pres == $past(t.set) && !t.done)
      else $error("timer did not reload while off");
   chk_tmr_done: assert property (last_tick_s |=> t.pres == 16'h0000 && t.done)
      else $error("timer flag missing at zero");
   chk_tmr_hold: assert property (t.en && !t.tick |=> $stable(t.pres))
      else $error("timer moved without a tick");
endmodule

/* File: rtl/pfi_range_cmp.sv */
// table of lower/upper bcd limit pairs tested against one data word
// assumes limits are packed lowest range first, lower limit in the low half
`timescale 1ns/100ps
module pfi_range_cmp (
   input  wire logic [pfi_pkg::NRANGE*32-1:0] lim,
   input  wire logic [15:0]                   data,
   input  wire logic [3:0]                    count,
   output logic      [15:0]                   hits
);
   // ==========================================================
   // one comparator per range, unused bits stay off
   for (genvar i = 0; i < 16; i++) begin : g_rng
      if (i < pfi_pkg::NRANGE) begin : g_used
         // bcd words order the same as binary
         assign hits[i] = (4'(i) < count) &&
                          data >= lim[32*i+:16] &&
                          data <= lim[32*i+16+:16];
      end else begin : g_off
         assign hits[i] = 1'b0;
      end
   end
endmodule

/* File: rtl/pfi_top.sv */
// function instruction execution: edge bits, latch, timers, counters,
// moves, compares, shift register and range tables
// assumes scan_strobe pulses once per program scan from same-clock logic,
// and program operands come from that same logic; pins are asynchronous
`timescale 1ns/100ps
module pfi_top #(
   parameter logic [3:0][25:0] TB_CYC = {26'(pfi_pkg::TB_1S_CYC),
                                         26'(pfi_pkg::TB_100MS_CYC),
                                         26'(pfi_pkg::TB_10MS_CYC),
                                         26'(pfi_pkg::TB_1MS_CYC)}
) (
   input  wire logic                               clk,
   input  wire logic                               rst_b,
   input  wire logic                               scan_strobe,
   input  wire logic                               rise_cond,
   output logic                                    rise_bit,
   input  wire logic                               fall_cond,
   output logic                                    fall_bit,
   input  wire logic                               latch_set,
   input  wire logic                               latch_rst,
   output logic                                    latch_bit,
   input  wire logic [4:0]                         tmr_en,
   input  wire logic [15:0]                        fine_set,
   input  wire logic [15:0]                        ms_set,
   input  wire logic [15:0]                        rng1_code,
   input  wire logic [15:0]                        rng2_code,
   input  wire logic [7:0]                         knob1_pin,
   input  wire logic [7:0]                         knob2_pin,
   output logic      [4:0][15:0]                   tmr_pres,
   output logic      [4:0]                         tmr_done,
   input  wire logic                               pulse_pin,
   input  wire logic                               fast_start,
   input  wire logic                               fast_rst,
   input  wire logic [15:0]                        fast_set,
   output logic      [15:0]                        fast_pres,
   output logic                                    fast_done,
   input  wire logic                               drum_cond,
   input  wire logic                               drum_down,
   input  wire logic                               drum_rst,
   input  wire logic [pfi_pkg::TBL_WORDS*16-1:0]   drum_table,
   output logic      [15:0]                        drum_pres,
   output logic      [15:0]                        drum_hits,
   input  wire logic                               copy_en,
   input  wire logic [15:0]                        copy_src,
   output logic      [15:0]                        copy_dst,
   output logic                                    copy_eq,
   input  wire logic                               inv_en,
   input  wire logic [15:0]                        inv_src,
   output logic      [15:0]                        inv_dst,
   output logic                                    inv_eq,
   input  wire logic                               cmpr_en,
   input  wire logic [15:0]                        cmpr_a,
   input  wire logic [15:0]                        cmpr_b,
   output logic                                    cmpr_eq,
   output logic                                    cmpr_lt,
   output logic                                    cmpr_gt,
   input  wire logic                               shift_data,
   input  wire logic                               shift_pulse,
   input  wire logic                               shift_rst,
   output logic      [15:0]                        shift_word,
   input  wire logic                               blk_en,
   input  wire logic [15:0]                        blk_data,
   input  wire logic [pfi_pkg::TBL_WORDS*16-1:0]   blk_table,
   output logic      [15:0]                        blk_result
);
   // ==========================================================
   // functions
   // clamp a knob reading into its span, as bcd
   function automatic logic [15:0] knob_set(input logic [7:0] k);
      logic [7:0] c;
      c = k;
      if (k < pfi_pkg::POT_MIN) c = pfi_pkg::POT_MIN;
      if (k > pfi_pkg::POT_MAX) c = pfi_pkg::POT_MAX;
      return pfi_pkg::bin8_to_bcd(c);
   endfunction

   // unit tick picked by a range code, none for an illegal code
   function automatic logic rng_tick(input logic [15:0] code,
                                     input logic [3:0] tk);
      logic r;
      r = 1'b0;
      if (code == pfi_pkg::RNG_1S) r = tk[pfi_pkg::TB_1S];
      if (code == pfi_pkg::RNG_100MS) r = tk[pfi_pkg::TB_100MS];
      if (code == pfi_pkg::RNG_10MS) r = tk[pfi_pkg::TB_10MS];
      return r;
   endfunction

   // range count from a table head digit, capped at the table size
   function automatic logic [3:0] head_count(input logic [3:0] d, input logic plus1);
      logic [4:0] n;
      n = {1'b0, d} + {4'h0, plus1};
      if (n > {1'b0, pfi_pkg::NRANGE_D}) n = {1'b0, pfi_pkg::NRANGE_D};
      return n[3:0];
   endfunction

   // ==========================================================
   // pin synchronisers
   logic [16:0] sync1_reg;
   logic [16:0] sync2_reg;
   logic        pulse_prev_reg;
   logic        pulse_rise;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sync1_reg <= 17'h00000;
         sync2_reg <= 17'h00000;
         pulse_prev_reg <= 1'b0;
      end else begin
         sync1_reg <= {pulse_pin, knob2_pin, knob1_pin};
         sync2_reg <= sync1_reg;
         pulse_prev_reg <= sync2_reg[16];
      end
   end
   assign pulse_rise = sync2_reg[16] && !pulse_prev_reg;

   // ==========================================================
   // time base dividers
   logic [3:0][25:0] div_reg;
   logic [3:0]       tick_reg;

   for (genvar i = 0; i < pfi_pkg::NTB; i++) begin : g_tb
      always_ff @(posedge clk) begin
         if (!rst_b) begin
            div_reg[i] <= 26'h0000000;
            tick_reg[i] <= 1'b0;
         end else begin
            tick_reg[i] <= div_reg[i] == TB_CYC[i] - 26'h0000001;
            if (div_reg[i] == TB_CYC[i] - 26'h0000001) div_reg[i] <= 26'h0000000;
            else div_reg[i] <= div_reg[i] + 26'h0000001;
         end
      end
   end

   // ==========================================================
   // timers
   pfi_tmr_if tif [pfi_pkg::NTMR] ();
   logic [4:0]       unit_tick;
   logic [4:0][15:0] unit_set;

   // unit and reload value for each timer
   always_comb begin
      unit_tick[pfi_pkg::TMR_FINE] = tick_reg[pfi_pkg::TB_10MS];
      unit_tick[pfi_pkg::TMR_MS]   = tick_reg[pfi_pkg::TB_1MS];
      unit_tick[pfi_pkg::TMR_POT]  = tick_reg[pfi_pkg::TB_100MS];
      unit_tick[pfi_pkg::TMR_RNG1] = rng_tick(rng1_code, tick_reg);
      unit_tick[pfi_pkg::TMR_RNG2] = rng_tick(rng2_code, tick_reg);
      unit_set[pfi_pkg::TMR_FINE]  = fine_set;
      unit_set[pfi_pkg::TMR_MS]    = ms_set;
      unit_set[pfi_pkg::TMR_POT]   = knob_set(sync2_reg[7:0]);
      unit_set[pfi_pkg::TMR_RNG1]  = knob_set(sync2_reg[7:0]);
      unit_set[pfi_pkg::TMR_RNG2]  = knob_set(sync2_reg[15:8]);
   end

   for (genvar i = 0; i < pfi_pkg::NTMR; i++) begin : g_tmr
      assign tif[i].en   = tmr_en[i];
      assign tif[i].tick = unit_tick[i];
      assign tif[i].set  = unit_set[i];
      assign tmr_pres[i] = tif[i].pres;
      assign tmr_done[i] = tif[i].done;
      pfi_bcd_timer u_tmr (
         .clk   (clk),
         .rst_b (rst_b),
         .t     (tif[i].tmr)
      );
   end

   // ==========================================================
   // edge pulses and latch, evaluated at each scan
   logic rise_prev_reg;
   logic fall_prev_reg;
   logic rise_bit_next;
   logic fall_bit_next;

   assign rise_bit_next = rise_cond && !rise_prev_reg;
   assign fall_bit_next = !fall_cond && fall_prev_reg;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rise_prev_reg <= 1'b0;
         fall_prev_reg <= 1'b0;
         rise_bit <= 1'b0;
         fall_bit <= 1'b0;
      end else if (scan_strobe) begin
         rise_prev_reg <= rise_cond;
         fall_prev_reg <= fall_cond;
         rise_bit <= rise_bit_next;
         fall_bit <= fall_bit_next;
      end
   end

   // reset wins when both inputs are on
   always_ff @(posedge clk) begin
      if (!rst_b) latch_bit <= 1'b0;
      else if (scan_strobe && latch_rst) latch_bit <= 1'b0;
      else if (scan_strobe && latch_set) latch_bit <= 1'b1;
   end

   // ==========================================================
   // fast up-counter, runs at clock rate on the pulse pin
   logic [15:0] fast_inc;
   logic        fast_hit;

   assign fast_inc = pfi_pkg::bcd_inc(fast_pres);
   // 9999 wraps to 0000, so a target of 0000 is ten thousand counts
   assign fast_hit = fast_start && !fast_rst && pulse_rise &&
                     fast_inc == fast_set;

   always_ff @(posedge clk) begin
      if (!rst_b) fast_pres <= pfi_pkg::WORD_ZERO;
      else if (fast_rst) fast_pres <= pfi_pkg::WORD_ZERO;
      else if (fast_hit) fast_pres <= pfi_pkg::WORD_ZERO;
      else if (fast_start && pulse_rise) fast_pres <= fast_inc;
   end

   // a new hit wins over the end-of-scan clear
   always_ff @(posedge clk) begin
      if (!rst_b) fast_done <= 1'b0;
      else if (fast_hit) fast_done <= 1'b1;
      else if (scan_strobe) fast_done <= 1'b0;
   end

   // ==========================================================
   // reversible drum counter and its range table
   logic        drum_prev_reg;
   logic [15:0] drum_match;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         drum_prev_reg <= 1'b0;
         drum_pres <= pfi_pkg::WORD_ZERO;
      end else if (scan_strobe) begin
         drum_prev_reg <= drum_cond;
         if (drum_rst) drum_pres <= pfi_pkg::WORD_ZERO;
         else if (drum_cond && !drum_prev_reg) begin
            drum_pres <= drum_down ? pfi_pkg::bcd_dec(drum_pres)
                                   : pfi_pkg::bcd_inc(drum_pres);
         end
      end
   end

   pfi_range_cmp u_drum (
      .lim   (drum_table[pfi_pkg::TBL_WORDS*16-1:16]),
      .data  (drum_pres),
      .count (head_count(drum_table[3:0], 1'b0)),
      .hits  (drum_match)
   );

   always_ff @(posedge clk) begin
      if (!rst_b) drum_hits <= pfi_pkg::WORD_ZERO;
      else drum_hits <= drum_match;
   end

   // ==========================================================
   // moves and compare
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         copy_dst <= pfi_pkg::WORD_ZERO;
         copy_eq <= 1'b0;
      end else if (scan_strobe && copy_en) begin
         copy_dst <= copy_src;
         copy_eq <= copy_src == pfi_pkg::WORD_ZERO;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         inv_dst <= pfi_pkg::WORD_ZERO;
         inv_eq <= 1'b0;
      end else if (scan_strobe && inv_en) begin
         inv_dst <= ~inv_src;
         inv_eq <= inv_src == 16'hffff;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cmpr_eq <= 1'b0;
         cmpr_lt <= 1'b0;
         cmpr_gt <= 1'b0;
      end else if (scan_strobe && cmpr_en) begin
         cmpr_eq <= cmpr_a == cmpr_b;
         cmpr_lt <= cmpr_a < cmpr_b;
         cmpr_gt <= cmpr_a > cmpr_b;
      end
   end

   // ==========================================================
   // shift register, reset has priority
   logic shift_prev_reg;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         shift_prev_reg <= 1'b0;
         shift_word <= pfi_pkg::WORD_ZERO;
      end else if (scan_strobe) begin
         shift_prev_reg <= shift_pulse;
         if (shift_rst) shift_word <= pfi_pkg::WORD_ZERO;
         else if (shift_pulse && !shift_prev_reg) begin
            shift_word <= {shift_word[14:0], shift_data};
         end
      end
   end

   // ==========================================================
   // block range compare
   logic [15:0] blk_match;

   pfi_range_cmp u_blk (
      .lim   (blk_table[pfi_pkg::TBL_WORDS*16-1:16]),
      .data  (blk_data),
      .count (head_count(blk_table[3:0], 1'b1)),
      .hits  (blk_match)
   );

   always_ff @(posedge clk) begin
      if (!rst_b) blk_result <= pfi_pkg::WORD_ZERO;
      else if (scan_strobe && blk_en) blk_result <= blk_match;
   end

   // ==========================================================
   // checks
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence fast_hit_s;
      fast_hit;
   endsequence

   chk_rise_one_scan: assert property (scan_strobe |=> rise_bit == $past(rise_bit_next))
      else $error("rise pulse wrong after scan");
   chk_fall_pulse: assert property (!scan_strobe |=> $stable(fall_bit))
      else $error("fall pulse changed inside a scan");
   chk_latch_hold: assert property (latch_bit && !(scan_strobe && latch_rst) |=> latch_bit)
      else $error("latch dropped without reset");
   chk_fast_gate: assert property (!fast_start && !fast_rst |=> $stable(fast_pres))
      else $error("fast counter moved while stopped");
   chk_fast_wrap: assert property (fast_hit_s |=> fast_pres == 16'h0000 && fast_done)
      else $error("fast counter did not clear at target");
   chk_fast_flag: assert property (fast_done && scan_strobe && !fast_hit |=> !fast_done)
      else $error("fast flag outlived its scan");
   chk_copy_eq: assert property (scan_strobe && copy_en |=>
      copy_dst == $past(copy_src) && copy_eq == (copy_dst == 16'h0000))
      else $error("copy result or flag wrong");
   chk_inv_eq: assert property (scan_strobe && inv_en |=>
      inv_dst == ~$past(inv_src) && inv_eq == (inv_dst == 16'h0000))
      else $error("inverted copy result or flag wrong");
   chk_cmpr_onehot: assert property (scan_strobe && cmpr_en |=>
      $onehot({cmpr_eq, cmpr_lt, cmpr_gt}) && cmpr_lt == ($past(cmpr_a) < $past(cmpr_b)))
      else $error("compare flags not exclusive");
   chk_shift_clear: assert property (scan_strobe && shift_rst |=> shift_word == 16'h0000)
      else $error("shift register not cleared");
endmodule

/* File: sim/plc_function_instructions_tb_top.sv */
// bench for pfi_top: scan instructions, a timer and the fast counter
// assumes the design's own assertions run alongside
`timescale 1ns/100ps
module plc_function_instructions_tb_top;
   // ==========================================
   // signals
   logic        clk = 0, rst_b = 0, scan_strobe = 0, rise_cond = 0, fall_cond = 0;
   logic        latch_set = 0, latch_rst = 0, pulse_pin = 0, fast_start = 0, fast_rst = 0;
   logic        drum_cond = 0, drum_down = 0, drum_rst = 0, copy_en = 0, inv_en = 0;
   logic        cmpr_en = 0, shift_data = 0, shift_pulse = 0, shift_rst = 0, blk_en = 0;
   logic        rise_bit, fall_bit, latch_bit, fast_done, copy_eq, inv_eq;
   logic        cmpr_eq, cmpr_lt, cmpr_gt, strb_d = 0, rc_p = 0, fc_p = 0, sp_p = 0, lt_m = 0;
   logic        dc_p = 0;
   int          dp_m = 0;
   logic [15:0] fine_set = 0, ms_set = 0, rng1_code = 0, rng2_code = 0, fast_set = 0;
   logic [15:0] copy_src = 0, inv_src = 0, cmpr_a = 0, cmpr_b = 0, blk_data = 0, sh_m = 0;
   logic [15:0] fast_pres, drum_pres, drum_hits, copy_dst, inv_dst, shift_word, blk_result;
   logic [7:0]  knob1_pin = 0, knob2_pin = 0;
   logic [4:0]  tmr_en = 0, tmr_done;
   logic [4:0][15:0] tmr_pres;
   logic [pfi_pkg::TBL_WORDS*16-1:0] drum_table = 0, blk_table = 0;
   logic [71:0] exp_q[$];
   int          error_cnt = 0, compares = 0, cyc = 0;
   wire  [71:0] res = {rise_bit, fall_bit, latch_bit, copy_eq, inv_eq, cmpr_eq, cmpr_lt,
                       cmpr_gt, copy_dst, inv_dst, shift_word, blk_result};

   pfi_top #(.TB_CYC({26'd40, 26'd20, 26'd10, 26'd5})) uut (.*);

   // clock, strobe history and hang limit
   always #10 clk = ~clk;
   always @(posedge clk) strb_d <= scan_strobe;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         results();
      end
   end
   // watcher: oldest note against the scan results
   always @(negedge clk) if (strb_d) chk(exp_q.pop_front(), res);

   // ==========================================
   // tasks
   function automatic logic [15:0] rb();
      rb = {4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10), 4'($urandom % 10)};
   endfunction
   task automatic chk(input logic [71:0] e, input logic [71:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic scan(input logic sr);
      logic [15:0] h;
      logic [15:0] dh;
      logic [15:0] g;
      @(negedge clk);
      {rise_cond, fall_cond, latch_set, latch_rst, shift_data, shift_pulse, drum_cond,
       drum_down} = 8'($urandom);
      shift_rst = sr;
      drum_rst = sr;
      copy_src = ($urandom % 4 == 0) ? 16'h0000 : rb();
      inv_src = ($urandom % 4 == 0) ? 16'hffff : rb();
      cmpr_a = rb();
      cmpr_b = ($urandom % 3 == 0) ? cmpr_a : rb();
      blk_data = rb();
      blk_table[15:0] = {12'h000, 4'($urandom % 10)};
      for (int k = 0; k < 10; k++) begin
         blk_table[32*k+16+:16] = rb();
         blk_table[32*k+32+:16] = blk_table[32*k+16+:16] | 16'h0999;
      end
      drum_table = blk_table;
      h = 16'h0000;
      for (int k = 0; k <= int'(blk_table[3:0]); k++)
         if (blk_data >= blk_table[32*k+16+:16] && blk_data <= blk_table[32*k+32+:16]) h[k] = 1;
      lt_m = latch_rst ? 1'b0 : (latch_set | lt_m);
      if (sr) sh_m = 16'h0000;
      else if (shift_pulse && !sp_p) sh_m = {sh_m[14:0], shift_data};
      // drum model: decimal count, ranges taken from the head digit with no extra range
      if (sr) dp_m = 0;
      else if (drum_cond && !dc_p) dp_m = drum_down ? (dp_m + 9999) % 10000 : (dp_m + 1) % 10000;
      dc_p = drum_cond;
      dh = {4'(dp_m / 1000), 4'(dp_m / 100 % 10), 4'(dp_m / 10 % 10), 4'(dp_m % 10)};
      g = 16'h0000;
      for (int k = 0; k < int'(blk_table[3:0]); k++)
         if (dh >= blk_table[32*k+16+:16] && dh <= blk_table[32*k+32+:16]) g[k] = 1;
      exp_q.push_back({rise_cond & !rc_p, !fall_cond & fc_p, lt_m, copy_src == 16'h0000,
                       inv_src == 16'hffff, cmpr_a == cmpr_b, cmpr_a < cmpr_b,
                       cmpr_a > cmpr_b, copy_src, ~inv_src, sh_m, h});
      {rc_p, fc_p, sp_p} = {rise_cond, fall_cond, shift_pulse};
      scan_strobe = 1;
      @(negedge clk);
      scan_strobe = 0;
      @(negedge clk);
      chk(72'({drum_pres, drum_hits}), 72'({dh, g}));
   endtask
   task automatic results();
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ==========================================
   // main sequence
   initial begin
      int n;
      void'($urandom(65321));
      {knob1_pin, knob2_pin} = 16'($urandom);
      rng1_code = 16'($urandom % 3);
      rng2_code = 16'($urandom % 3);
      fine_set = rb();
      {copy_en, inv_en, cmpr_en, blk_en} = 4'hf;
      repeat (21) @(negedge clk);
      rst_b = 1;
      scan(1'b1);
      repeat (40) scan($urandom % 8 == 0);
      ms_set = 16'h0003;
      repeat (3) @(negedge clk);
      chk(72'({tmr_done[1], tmr_pres[1]}), 72'h0_0003);
      tmr_en = 5'h1f;
      n = 0;
      while (tmr_done[1] !== 1'b1 && n < 40) begin
         @(negedge clk);
         n++;
      end
      chk(72'({tmr_pres[1], n >= 10 && n <= 17}), 72'h0_0001);
      tmr_en = 5'h00;
      repeat (2) @(negedge clk);
      chk(72'({tmr_done[1], tmr_pres[1]}), 72'h0_0003);
      fast_set = 16'h0003;
      fast_start = 1;
      for (int i = 0; i < 3; i++) begin
         pulse_pin = 1;
         repeat (2) @(negedge clk);
         pulse_pin = 0;
         repeat (4) @(negedge clk);
         chk(72'({fast_done, fast_pres}), (i == 2) ? 72'h1_0000 : 72'(i + 1));
      end
      scan(1'b0);
      chk(72'(fast_done), 72'h0);
      results();
   end
endmodule
